//--- verilog/icls_top.v
// Input current limit selector: CC sink, D+/D- result mapping, boost role,
// charge settings and inhibit, with an AXI4-Lite register slave.
// Assumes all pin inputs synchronous to aclk; analog sensing is outside.
//
// What this block does
// (RQ1) Proprietary adapter types map to fixed limits
// (RQ2) Type-C sink sets limit from CC
// (RQ3) Pick active CC line after attach
// (RQ4) Classify CC advert: 500mA, 1.5A, 3A
// (RQ5) Track advertised changes while attached
// (RQ6) Apply larger of D+/D- and CC limits
// (RQ7) Open D+/D- forces 3A final limit
// (RQ8) Floating CC: limit from D+/D- only
// (RQ9) Boost removes Rd, enables source current
// (RQ10) Boost drives reverse 5.1V source output
// (RQ11) Fast-charge current from fifteen resistor settings
// (RQ12) Top-off threshold from six resistor settings
// (RQ13) Inhibit pin low stops charging
// (RQ14) Controller checks input valid before inhibit
// (RQ15) Controller drives inhibit open-drain
// (RQ16) Shared D+/D- released until input valid
// (RQ17) SDP 500mA, CDP/DCP 1.5A, else 3A
// (RQ18) Input valid low when powered or boosting
// (RQ19) Limit recomputed from current detector results
//
// Design decisions made here: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "icls_map.vh"

module icls_top #(
    parameter DEB_US  = `ICLS_DEB_US,
    parameter CLK_MHZ = `ICLS_CLK_MHZ,
    parameter DEB_CYC = DEB_US * CLK_MHZ
) (
    // Clock and reset
    input  wire        aclk,
    input  wire        aresetn,
    // AXI4-Lite write address
    input  wire [3:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    // AXI4-Lite write data
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    // AXI4-Lite write response
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    // AXI4-Lite read
    input  wire [3:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    // Detector inputs
    input  wire [1:0]  cc1_level,
    input  wire [1:0]  cc2_level,
    input  wire [3:0]  dpdm_type,
    input  wire        dpdm_done,
    // Power pins
    input  wire        boost_enable_pin,
    input  wire        input_present,
    input  wire        buck_switching,
    input  wire        topoff_set_inhibit_pin,
    input  wire [3:0]  fast_charge_current_set,
    input  wire [2:0]  topoff_set_resistor,
    // Outputs to the power stage
    output reg  [11:0] input_limit_ma,
    output reg  [11:0] fast_ma,
    output reg  [11:0] topoff_ma,
    output reg         charge_enable,
    output reg         rd_connect,
    output reg         cc_source_en,
    output reg         reverse_boost_en,
    output wire        input_valid_n_o,
    output wire        input_valid_n_oe
);

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    reg  [31:0] ctrl;
    wire        boost_req = boost_enable_pin | ctrl[`ICLS_CTRL_BOOST];
    wire        inhibit   = !topoff_set_inhibit_pin | ctrl[`ICLS_CTRL_INH];

    // ----------------------------------------------------------------
    // Detectors
    // ----------------------------------------------------------------
    wire        cc_att;
    wire        cc_act2;
    wire [11:0] cc_lim;
    wire [11:0] fast_w;
    wire [11:0] topoff_w;

    icls_cc_sink #(
        .DEB_CYC (DEB_CYC)
    ) u_cc (
        .aclk        (aclk),
        .aresetn     (aresetn),
        .cc1_level   (cc1_level),
        .cc2_level   (cc2_level),
        .source_role (boost_req),
        .attached    (cc_att),
        .active_cc2  (cc_act2),
        .cc_limit    (cc_lim)
    );

    icls_tables u_tab (
        .fast_sel   (fast_charge_current_set),
        .topoff_sel (topoff_set_resistor),
        .fast_ma    (fast_w),
        .topoff_ma  (topoff_w)
    );

    // D+/D- result to limit
    reg [11:0] dp_lim;
    always @* begin
        case (dpdm_type)
            `ICLS_DP_SDP:    dp_lim = `ICLS_LIM_500;    // [RQ17]
            `ICLS_DP_CDP:    dp_lim = `ICLS_LIM_1500;   // [RQ17]
            `ICLS_DP_DCP:    dp_lim = `ICLS_LIM_1500;   // [RQ17]
            `ICLS_DP_VA_500: dp_lim = `ICLS_LIM_500;    // [RQ1]
            `ICLS_DP_VA_1A:  dp_lim = `ICLS_LIM_1000;   // [RQ1]
            `ICLS_DP_VA_2A:  dp_lim = `ICLS_LIM_2000;   // [RQ1]
            `ICLS_DP_VA_24A: dp_lim = `ICLS_LIM_2400;   // [RQ1]
            `ICLS_DP_VB_2A:  dp_lim = `ICLS_LIM_2000;   // [RQ1]
            default:         dp_lim = `ICLS_LIM_3000;   // [RQ1] [RQ7] [RQ17]
        endcase
    end

    // Until D+/D- finishes, only CC counts; floating CC gives 0 so D+/D- wins
    wire [11:0] dp_eff   = dpdm_done ? dp_lim : `ICLS_LIM_0;
    wire        dp_open  = dpdm_done && (dpdm_type == `ICLS_DP_OPEN || dpdm_type == `ICLS_DP_NONE);
    wire [11:0] max_lim  = (cc_lim > dp_eff) ? cc_lim : dp_eff;              // [RQ6] [RQ8]
    wire [11:0] next_lim = dp_open ? `ICLS_LIM_3000 : max_lim;               // [RQ7]

    // ----------------------------------------------------------------
    // Power stage control
    // ----------------------------------------------------------------
    reg in_valid;
    always @(posedge aclk) begin
        if (!aresetn) begin
            input_limit_ma   <= `ICLS_LIM_0;
            fast_ma          <= `ICLS_LIM_0;
            topoff_ma        <= `ICLS_LIM_0;
            charge_enable    <= 1'b0;
            rd_connect       <= 1'b1;
            cc_source_en     <= 1'b0;
            reverse_boost_en <= 1'b0;
            in_valid         <= 1'b0;
        end else begin
            input_limit_ma   <= boost_req ? `ICLS_LIM_0 : next_lim;           // [RQ19]
            fast_ma          <= fast_w;                                       // [RQ11]
            topoff_ma        <= topoff_w;                                     // [RQ12]
            charge_enable    <= !boost_req && input_present && !inhibit;      // [RQ13]
            rd_connect       <= !boost_req;                                   // [RQ9]
            cc_source_en     <= boost_req;                                    // [RQ9]
            reverse_boost_en <= boost_req;                                    // [RQ10]
            in_valid         <= boost_req || (input_present && buck_switching); // [RQ18]
        end
    end

    // Open-drain: drive low only, release otherwise
    assign input_valid_n_o  = 1'b0;
    assign input_valid_n_oe = in_valid;                                       // [RQ18]

    // ----------------------------------------------------------------
    // AXI4-Lite slave
    // ----------------------------------------------------------------
    reg        aw_held;
    reg        w_held;
    reg [3:0]  aw_addr;
    reg [31:0] w_data;
    reg [3:0]  w_strb;

    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready  = !w_held && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;

    wire aw_now = aw_held | (s_axi_awvalid & s_axi_awready);
    wire w_now  = w_held | (s_axi_wvalid & s_axi_wready);
    wire [3:0]  wa = aw_held ? aw_addr : s_axi_awaddr;
    wire [31:0] wd = w_held ? w_data : s_axi_wdata;
    wire [3:0]  ws = w_held ? w_strb : s_axi_wstrb;

    integer i;
    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_held      <= 1'b0;
            w_held       <= 1'b0;
            aw_addr      <= 4'h0;
            w_data       <= 32'h0000_0000;
            w_strb       <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `ICLS_RESP_OK;
            ctrl         <= `ICLS_CTRL_RST;
        end else begin
            if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
            if (aw_now && w_now && !s_axi_bvalid) begin
                aw_held      <= 1'b0;
                w_held       <= 1'b0;
                s_axi_bvalid <= 1'b1;
                if (wa[3:2] == `ICLS_REG_CTRL >> 2) begin
                    s_axi_bresp <= `ICLS_RESP_OK;
                    for (i = 0; i < 4; i = i + 1)
                        if (ws[i])
                            ctrl[i*8 +: 8] <= wd[i*8 +: 8];
                end else begin
                    s_axi_bresp <= `ICLS_RESP_SLVERR;
                end
            end else begin
                if (s_axi_awvalid && s_axi_awready) begin
                    aw_held <= 1'b1;
                    aw_addr <= s_axi_awaddr;
                end
                if (s_axi_wvalid && s_axi_wready) begin
                    w_held <= 1'b1;
                    w_data <= s_axi_wdata;
                    w_strb <= s_axi_wstrb;
                end
            end
        end
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= `ICLS_RESP_OK;
        end else if (s_axi_rvalid) begin
            if (s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end else if (s_axi_arvalid) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= `ICLS_RESP_OK;
            case (s_axi_araddr[3:2])
                `ICLS_REG_CTRL >> 2: s_axi_rdata <= ctrl;
                `ICLS_REG_STAT >> 2: s_axi_rdata <= {24'h00_0000, dpdm_type, in_valid,
                                                     charge_enable, cc_act2, cc_att};
                `ICLS_REG_LIM >> 2:  s_axi_rdata <= {20'h0_0000, input_limit_ma};
                `ICLS_REG_SET >> 2:  s_axi_rdata <= {4'h0, topoff_ma, 4'h0, fast_ma};
                default:             s_axi_rdata <= 32'h0000_0000;
            endcase
        end
    end

endmodule

//--- verilog/icls_map.vh
// Constants for the input current limit selector: limit codes, detector codes,
// register offsets and field positions.
// Assumes inclusion by every design file of the selector.
`ifndef ICLS_MAP_VH
`define ICLS_MAP_VH

// Limits in mA, 12 bits
`define ICLS_LIM_0      12'h000
`define ICLS_LIM_100    12'h064
`define ICLS_LIM_500    12'h1F4
`define ICLS_LIM_1000   12'h3E8
`define ICLS_LIM_1500   12'h5DC
`define ICLS_LIM_2000   12'h7D0
`define ICLS_LIM_2400   12'h960
`define ICLS_LIM_3000   12'hBB8

// D+/D- detector result codes
`define ICLS_DP_NONE    4'h0
`define ICLS_DP_SDP     4'h1
`define ICLS_DP_CDP     4'h2
`define ICLS_DP_DCP     4'h3
`define ICLS_DP_VA_500  4'h4
`define ICLS_DP_VA_1A   4'h5
`define ICLS_DP_VA_2A   4'h6
`define ICLS_DP_VA_24A  4'h7
`define ICLS_DP_VB_2A   4'h8
`define ICLS_DP_UNKNOWN 4'h9
`define ICLS_DP_OPEN    4'hA

// CC advertisement levels seen on each CC wire
`define ICLS_CC_OPEN    2'h0
`define ICLS_CC_DEF     2'h1
`define ICLS_CC_1A5     2'h2
`define ICLS_CC_3A0     2'h3

// Register byte offsets
`define ICLS_REG_CTRL   4'h0
`define ICLS_REG_STAT   4'h4
`define ICLS_REG_LIM    4'h8
`define ICLS_REG_SET    4'hC

// CTRL fields
`define ICLS_CTRL_BOOST 0
`define ICLS_CTRL_INH   1
`define ICLS_CTRL_RST   32'h0000_0000

// Debounce for CC attach, 10 ms min
`define ICLS_DEB_US     10000
`define ICLS_CLK_MHZ    25

`define ICLS_RESP_OK    2'h0
`define ICLS_RESP_SLVERR 2'h2

`endif

//--- verilog/icls_tables.v
// Lookup of resistor-selected charge settings.
// Assumes index codes from an external resistance measurement.
`timescale 1ns/1ps
`include "icls_map.vh"

module icls_tables (
    // Selection codes
    input  wire [3:0]  fast_sel,
    input  wire [2:0]  topoff_sel,
    // Resulting currents in mA
    output reg  [11:0] fast_ma,
    output reg  [11:0] topoff_ma
);

    // Codes 0..14 low to high resistance; 15 clamps to lowest
    always @* begin
        case (fast_sel)
            4'h0: fast_ma = 12'h1F4;
            4'h1: fast_ma = 12'h258;
            4'h2: fast_ma = 12'h320;
            4'h3: fast_ma = 12'h3E8;
            4'h4: fast_ma = 12'h4B0;
            4'h5: fast_ma = 12'h578;
            4'h6: fast_ma = 12'h5DC;
            4'h7: fast_ma = 12'h708;
            4'h8: fast_ma = 12'h7D0;
            4'h9: fast_ma = 12'h898;
            4'hA: fast_ma = 12'h960;
            4'hB: fast_ma = 12'h9C4;
            4'hC: fast_ma = 12'hAF0;
            4'hD: fast_ma = 12'hBB8;
            4'hE: fast_ma = 12'hC4E;
            default: fast_ma = 12'h1F4;
        endcase
    end

    always @* begin
        case (topoff_sel)
            3'h0: topoff_ma = 12'h064;
            3'h1: topoff_ma = 12'h096;
            3'h2: topoff_ma = 12'h0C8;
            3'h3: topoff_ma = 12'h0FA;
            3'h4: topoff_ma = 12'h12C;
            3'h5: topoff_ma = 12'h15E;
            default: topoff_ma = 12'h064;
        endcase
    end

endmodule

//--- verilog/icls_cc_sink.v
// Type-C sink attach machine: debounce, active wire pick, level.
// Assumes CC levels already quantised by the analog front end.
`timescale 1ns/1ps
`include "icls_map.vh"

module icls_cc_sink #(
    parameter DEB_CYC = 250000
) (
    // Clock and reset
    input  wire        aclk,
    input  wire        aresetn,
    // Quantised CC levels and role
    input  wire [1:0]  cc1_level,
    input  wire [1:0]  cc2_level,
    input  wire        source_role,
    // Results
    output reg         attached,
    output reg         active_cc2,
    output reg  [11:0] cc_limit
);

    localparam ST_UNATT = 3'b001;
    localparam ST_WAIT  = 3'b010;
    localparam ST_ATT   = 3'b100;

    reg [2:0]  state;
    reg [31:0] deb_cnt;
    reg [1:0]  act_level;
    wire       any_cc  = (cc1_level != `ICLS_CC_OPEN) || (cc2_level != `ICLS_CC_OPEN);
    wire       pick2   = (cc2_level > cc1_level);
    wire [1:0] cur_lvl = active_cc2 ? cc2_level : cc1_level;

    always @(posedge aclk) begin
        if (!aresetn || source_role) begin
            state      <= ST_UNATT;
            deb_cnt    <= 32'h0000_0000;
            attached   <= 1'b0;
            active_cc2 <= 1'b0;
            act_level  <= `ICLS_CC_OPEN;
        end else begin
            case (state)
                ST_UNATT: begin
                    deb_cnt <= 32'h0000_0000;
                    if (any_cc)
                        state <= ST_WAIT;
                end
                ST_WAIT: begin
                    if (!any_cc) begin
                        state <= ST_UNATT;
                    end else if (deb_cnt >= DEB_CYC - 1) begin
                        state      <= ST_ATT;
                        attached   <= 1'b1;
                        active_cc2 <= pick2;              // [RQ3]
                        act_level  <= pick2 ? cc2_level : cc1_level;
                    end else begin
                        deb_cnt <= deb_cnt + 32'h0000_0001;
                    end
                end
                ST_ATT: begin
                    if (cur_lvl == `ICLS_CC_OPEN) begin
                        state    <= ST_UNATT;
                        attached <= 1'b0;
                    end else begin
                        act_level <= cur_lvl;             // [RQ5]
                    end
                end
                default: state <= ST_UNATT;
            endcase
        end
    end

    always @(posedge aclk) begin
        if (!aresetn)
            cc_limit <= `ICLS_LIM_0;
        else if (!attached)
            cc_limit <= `ICLS_LIM_0;
        else case (act_level)                              // [RQ2] [RQ4]
            `ICLS_CC_3A0: cc_limit <= `ICLS_LIM_3000;
            `ICLS_CC_1A5: cc_limit <= `ICLS_LIM_1500;
            default:      cc_limit <= `ICLS_LIM_500;
        endcase
    end

endmodule

//--- test/icls_properties.sv
// Port checker for the input current limit selector.
// Assumes a bind onto icls_top; one clock domain.
`timescale 1ns/1ps
module icls_props (
    // Clock and reset
    input wire        aclk,
    input wire        aresetn,
    // Detector and pin inputs
    input wire [1:0]  cc1_level,
    input wire [1:0]  cc2_level,
    input wire [3:0]  dpdm_type,
    input wire        dpdm_done,
    input wire        boost_enable_pin,
    input wire        input_present,
    input wire        buck_switching,
    input wire        topoff_set_inhibit_pin,
    input wire [3:0]  fast_charge_current_set,
    input wire [2:0]  topoff_set_resistor,
    // Outputs
    input wire [11:0] input_limit_ma,
    input wire [11:0] fast_ma,
    input wire [11:0] topoff_ma,
    input wire        charge_enable,
    input wire        rd_connect,
    input wire        cc_source_en,
    input wire        reverse_boost_en,
    input wire        input_valid_n_oe
);
    // ----------
    // Properties
    // ----------
    // Code 0 sits in the low slice
    localparam [191:0] FAST_T = {12'h1F4, 12'hC4E, 12'hBB8, 12'hAF0, 12'h9C4, 12'h960, 12'h898, 12'h7D0,
                                 12'h708, 12'h5DC, 12'h578, 12'h4B0, 12'h3E8, 12'h320, 12'h258, 12'h1F4};
    localparam [95:0]  TOP_T  = {12'h064, 12'h064, 12'h15E, 12'h12C, 12'h0FA, 12'h0C8, 12'h096, 12'h064};
    wire dp_open  = aresetn && dpdm_done && (dpdm_type == 4'hA || dpdm_type == 4'h0);
    wire chg_ok   = topoff_set_inhibit_pin && input_present && !boost_enable_pin;
    wire sdp_bare = cc1_level == 2'h0 && cc2_level == 2'h0 && dpdm_done && dpdm_type == 4'h1;

    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    chk_boost_role:
    assert property (boost_enable_pin |=> !rd_connect && cc_source_en && reverse_boost_en)
        else $error("boost role outputs wrong");
    chk_valid_pull:
    assert property ((boost_enable_pin || (input_present && buck_switching)) |=> input_valid_n_oe)
        else $error("input valid not pulled");
    chk_inhibit_stop:
    assert property (!topoff_set_inhibit_pin |=> !charge_enable)
        else $error("charging while inhibited");
    chk_charge_cause:
    assert property ($rose(charge_enable) |-> $past(chg_ok))
        else $error("charging without cause");
    chk_open_lines:
    assert property ($past(dp_open) && !reverse_boost_en |-> input_limit_ma == 12'hBB8)
        else $error("open lines limit wrong");
    chk_fast_table:
    assert property ($past(aresetn) && $stable(fast_charge_current_set)
                     |-> fast_ma == FAST_T[fast_charge_current_set * 12 +: 12])
        else $error("fast charge current wrong");
    chk_top_table:
    assert property ($past(aresetn) && $stable(topoff_set_resistor)
                     |-> topoff_ma == TOP_T[topoff_set_resistor * 12 +: 12])
        else $error("top-off current wrong");
    chk_sdp_only:
    assert property (sdp_bare [*4] |=> reverse_boost_en || input_limit_ma == 12'h1F4)
        else $error("limit without CC wrong");
endmodule

//--- test/icls_src_model.sv
// Adapter model: CC advert and D+/D- result as seen by the selector.
// Assumes bench commands that change just after a clock edge.
`timescale 1ns/1ps
module icls_src_model #(
    parameter DET_CYC = 6
) (
    // Clock
    input wire       aclk,
    // Commands
    input wire       plugged,
    input wire       flip,
    input wire [1:0] cc_adv,
    input wire [3:0] dp_kind,
    // Detector side
    output reg [1:0] cc1_level,
    output reg [1:0] cc2_level,
    output reg [3:0] dpdm_type,
    output reg       dpdm_done
);
    // ---------
    // Behaviour
    // ---------
    reg  [3:0] cnt;
    wire       fin = plugged && cnt == DET_CYC;
    initial begin
        {cc1_level, cc2_level, dpdm_type, dpdm_done, cnt} = 13'h0;
    end
    always @(posedge aclk) begin
        // A plug carries the advert on one wire only
        cc1_level <= (plugged && !flip) ? cc_adv : 2'h0;
        cc2_level <= (plugged && flip) ? cc_adv : 2'h0;
        cnt       <= plugged ? cnt + (cnt != DET_CYC) : 4'h0;
        dpdm_done <= fin;
        // Result is junk until detection ends, so stale codes never look valid
        dpdm_type <= fin ? dp_kind : ~dpdm_type;
    end
endmodule

//--- test/test_input_current_limit_select.sv
// Self-checking bench for the input current limit selector.
// Assumes the adapter model and the port checker beside the design.
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin miscompares++; \
    $display("unexpected at %0t: got %h expected %h", $time, g, e); end end
module test_input_current_limit_select;
    logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [3:0] awaddr = 0, araddr = 0, dp_kind = 0, fast_set = 0, dp_type;
    logic [31:0] wdata = 0, rdata;
    logic awready, wready, bvalid, arready, rvalid, dp_done;
    logic [1:0] bresp, rresp, cc1, cc2, cc_adv = 0;
    logic [2:0] top_set = 0;
    logic plugged = 0, flip = 0, boost = 0, present = 0, sw = 0, pull = 0;
    logic [11:0] lim, fast_ma, top_ma;
    logic chg_en, rd_con, src_en, rev_en, iv_o, iv_oe;
    wire [4:0] role = {rd_con, src_en, rev_en, iv_oe, iv_o};
    // Open-drain with pull-up
    wire inh_pin = pull ? 1'h0 : 1'h1;
    int miscompares = 0, cmp_count = 0;

    // -------------------
    // Design and partner
    // -------------------
    icls_top #(.DEB_CYC(4)) i_dut (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .cc1_level(cc1), .cc2_level(cc2), .dpdm_type(dp_type), .dpdm_done(dp_done),
        .boost_enable_pin(boost), .input_present(present), .buck_switching(sw),
        .topoff_set_inhibit_pin(inh_pin), .fast_charge_current_set(fast_set),
        .topoff_set_resistor(top_set), .input_limit_ma(lim), .fast_ma(fast_ma), .topoff_ma(top_ma),
        .charge_enable(chg_en), .rd_connect(rd_con), .cc_source_en(src_en),
        .reverse_boost_en(rev_en), .input_valid_n_o(iv_o), .input_valid_n_oe(iv_oe));
    icls_src_model i_src (.aclk(aclk), .plugged(plugged), .flip(flip), .cc_adv(cc_adv), .dp_kind(dp_kind),
        .cc1_level(cc1), .cc2_level(cc2), .dpdm_type(dp_type), .dpdm_done(dp_done));

    initial begin
        forever #20 aclk = ~aclk;
    end

    task automatic wrap_up;
        $display("compares %0d miscompares %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic tmo;
        miscompares++;
        wrap_up;
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge aclk);
    endtask
    task automatic wr(input [3:0] a, input [31:0] d, input [1:0] er);
        int n;
        @(posedge aclk);
        awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
        for (n = 0; n < 30; n++) begin
            @(posedge aclk);
            if (awready) awvalid <= 0;
            if (wready) wvalid <= 0;
            if (bvalid) break;
        end
        if (n == 30) tmo;
        bready <= 0;
        `CHK(bresp, er)
    endtask
    task automatic rd(input [3:0] a, input [31:0] e);
        int n;
        @(posedge aclk);
        araddr <= a; arvalid <= 1; rready <= 1;
        for (n = 0; n < 30; n++) begin
            @(posedge aclk);
            if (arready) arvalid <= 0;
            if (rvalid) break;
        end
        if (n == 30) tmo;
        rready <= 0;
        `CHK(rdata, e)
        `CHK(rresp, 2'h0)
    endtask
    task automatic wait_lim(input [11:0] e);
        int n;
        for (n = 0; n < 60 && lim !== e; n++) @(posedge aclk);
        `CHK(lim, e)
        if (n == 60) wrap_up;
    endtask
    function automatic [11:0] dp_ma(input [3:0] k);
        case (k)
            4'h1, 4'h4: dp_ma = 12'h1F4;
            4'h2, 4'h3: dp_ma = 12'h5DC;
            4'h5:       dp_ma = 12'h3E8;
            4'h6, 4'h8: dp_ma = 12'h7D0;
            4'h7:       dp_ma = 12'h960;
            default:    dp_ma = 12'hBB8;
        endcase
    endfunction

    // ---------
    // Scenarios
    // ---------
    task automatic t_regs;
        int k;
        rd(4'h0, 32'h0);
        for (k = 1; k < 4; k++) wr({k[1:0], 2'h0}, 32'hFFFF_FFFF, 2'h2);
        rd(4'h0, 32'h0);
        rd(4'h8, 32'h0);
        for (k = 0; k < 16; k++) begin
            fast_set <= k[3:0]; top_set <= k[2:0];
            cyc(3);
        end
        fast_set <= 4'hE; top_set <= 3'h5;
        rd(4'hC, 32'h015E_0C4E);
    endtask
    task automatic t_dpdm;
        int k;
        for (k = 0; k <= 10; k++) begin
            @(posedge aclk);
            dp_kind <= k[3:0]; plugged <= 1;
            wait_lim(dp_ma(k[3:0]));
            plugged <= 0;
            wait_lim(12'h000);
        end
    endtask
    task automatic t_cc;
        int f;
        for (f = 0; f < 2; f++) begin
            @(posedge aclk);
            flip <= f[0]; cc_adv <= 2'h2; dp_kind <= 4'h1; plugged <= 1;
            wait_lim(12'h5DC);
            rd(4'h4, {24'h0, 4'h1, 2'h0, f[0], 1'h1});
            cc_adv <= 2'h3;
            wait_lim(12'hBB8);
            cc_adv <= 2'h1;
            wait_lim(12'h1F4);
            dp_kind <= 4'hA;
            wait_lim(12'hBB8);
            dp_kind <= 4'h7; cc_adv <= 2'h2;
            wait_lim(12'h960);
            plugged <= 0;
            wait_lim(12'h000);
        end
    endtask
    task automatic t_boost;
        @(posedge aclk);
        dp_kind <= 4'hA; plugged <= 1;
        wait_lim(12'hBB8);
        boost <= 1;
        cyc(2);
        `CHK(role, 5'h0E)
        `CHK(lim, 12'h000)
        boost <= 0;
        wr(4'h0, 32'h1, 2'h0);
        cyc(2);
        `CHK(role[4:2], 3'h3)
        rd(4'h0, 32'h1);
        wr(4'h0, 32'h0, 2'h0);
        wait_lim(12'hBB8);
        `CHK(rd_con, 1'h1)
        plugged <= 0;
        wait_lim(12'h000);
    endtask
    task automatic t_charge;
        @(posedge aclk);
        present <= 1; sw <= 1;
        cyc(2);
        // Shared D+/D- lines go to the controller only once input valid pulls
        `CHK(iv_oe, 1'h1)
        `CHK(chg_en, 1'h1)
        // Pulling the pin without valid input upsets top-off sensing
        if (iv_oe === 1'h1) pull <= 1;
        cyc(2);
        `CHK(chg_en, 1'h0)
        pull <= 0;
        cyc(2);
        `CHK(chg_en, 1'h1)
        wr(4'h0, 32'h2, 2'h0);
        cyc(2);
        `CHK(chg_en, 1'h0)
        wr(4'h0, 32'h0, 2'h0);
        present <= 0; sw <= 0;
    endtask

    initial begin
        cyc(5);
        aresetn <= 1;
        t_regs;
        t_dpdm;
        t_cc;
        t_boost;
        t_charge;
        wrap_up;
    end
endmodule

bind icls_top icls_props i_props (.*);
